// [hw/cap_core.sv]
// Charge accumulation and power mode controller with APB registers
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cap_core #(
  parameter int unsigned HALF_SEC_CYC = cap_pkg::HALF_SEC_CYC,
  parameter int unsigned SLP_TICK_CYC = cap_pkg::HALF_SEC_CYC,
  parameter int unsigned NVM_WORDS    = cap_pkg::NVM_WORDS
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_valid,
  input  wire logic [2:0]  conv_chan,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_cycle_done,
  output logic             conv_start,
  output logic             analog_on,
  output logic             offs_cal_active,
  input  wire logic        pack_above_por,
  input  wire logic        pack_below_trip,
  input  wire logic        aux_below_trip,
  input  wire logic        cur_below_trip,
  input  wire logic        chg_above_wake,
  input  wire logic        pack_above_wake,
  input  wire logic        shelf_req,
  output logic             nvm_rd,
  output logic      [4:0]  nvm_addr,
  input  wire logic [31:0] nvm_rdata,
  input  wire logic        nvm_ack,
  output logic      [2:0]  mode
);
  localparam int unsigned SW = cap_pkg::SLP_CNT_W;

  typedef struct packed {
    cap_pkg::cap_mode_t mode;
    logic [7:0]         acc_ctrl;
    logic [7:0]         conv_cfg;
    logic [7:0]         op_mode;
    logic [7:0]         trip_ctrl;
    logic [7:0]         offs_ctrl;
    logic [15:0]        offs_res;
    logic [15:0]        cur_res;
    logic [15:0]        itmp_res;
    logic [15:0]        etmp_res;
    logic [15:0]        aux_res;
    logic [SW-1:0]      samp_cnt;
    logic [SW-1:0]      slp_cnt;
    logic [4:0]         nvm_idx;
    logic               cyc_busy;
    logic               conv_start;
    logic               analog_on;
    logic               offs_act;
    logic [31:0]        prdata;
  } cap_core_st_t;

  cap_core_st_t st_r;
  cap_core_st_t st_nxt;

  logic        tick;
  logic        slp_tick;
  logic        active;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_mux;
  logic [31:0] cnt_val [cap_pkg::NUM_CNT];
  logic        cnt_add [cap_pkg::NUM_CNT];
  logic [31:0] cnt_inc [cap_pkg::NUM_CNT];
  logic        trip_hit;
  logic        wake;
  logic [14:0] cur_mag;
  logic [15:0] temp_res;
  cap_pkg::cap_mode_t run_pick;

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic cnt_hit(input logic [7:0] a);
    return a >= cap_pkg::OFS_CNT_BASE && a <= cap_pkg::OFS_CNT_LAST;
  endfunction : cnt_hit

  function automatic logic [2:0] cnt_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - cap_pkg::OFS_CNT_BASE;
    return d[4:2];
  endfunction : cnt_idx

  function automatic logic addr_ok(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= cap_pkg::OFS_STATUS;
  endfunction : addr_ok

  // Interval minus one in ticks
  function automatic logic [SW-1:0] lim(input logic [3:0] n);
    logic [SW:0] one;
    one = (SW+1)'(1);
    return SW'((one << n) - one);
  endfunction : lim

  // Keep only the selected resolution, zeros below
  function automatic logic [15:0] res_mask(input logic [2:0] r);
    logic [15:0] m;
    m = 16'hFFFF << (3'h7 - r);
    return m;
  endfunction : res_mask

  // ********************************************************
  // Time bases
  // ********************************************************
  assign active = st_r.mode == cap_pkg::M_RUN ||
                  st_r.mode == cap_pkg::M_SAMPLE ||
                  st_r.mode == cap_pkg::M_SLEEP;

  cap_tick_div #(
    .CYC (HALF_SEC_CYC)
  ) u_half_sec (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (active),
    .tick     (tick)
  );

  cap_tick_div #(
    .CYC (SLP_TICK_CYC)
  ) u_sleep_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (st_r.mode == cap_pkg::M_SLEEP),
    .tick     (slp_tick)
  );

  // ********************************************************
  // Accumulators and time counters
  // ********************************************************
  assign cur_mag  = st_r.cur_res[14:0];
  assign temp_res = st_r.acc_ctrl[cap_pkg::TEMP_SEL_BIT] ?
                    st_r.etmp_res : st_r.itmp_res;

  always_comb begin
    logic t;
    logic acc;
    logic sgn;
    logic nz;
    t   = tick && active;
    acc = st_r.acc_ctrl[cap_pkg::ACC_EN_BIT];
    sgn = st_r.cur_res[15];
    nz  = cur_mag != 15'h0000;
    cnt_add[cap_pkg::CNT_DCA]  = t && acc && sgn;
    cnt_add[cap_pkg::CNT_CCA]  = t && acc && !sgn;
    cnt_add[cap_pkg::CNT_TA]   = t && st_r.acc_ctrl[cap_pkg::TEMP_EN_BIT];
    cnt_add[cap_pkg::CNT_AUXA] = t && st_r.acc_ctrl[cap_pkg::AUX_EN_BIT];
    cnt_add[cap_pkg::CNT_DTC]  = t && sgn && nz;
    cnt_add[cap_pkg::CNT_CTC]  = t && !sgn && nz;
    cnt_add[cap_pkg::CNT_TTC]  = cnt_add[cap_pkg::CNT_TA];
    cnt_add[cap_pkg::CNT_ATC]  = cnt_add[cap_pkg::CNT_AUXA];
    cnt_inc[cap_pkg::CNT_DCA]  = {17'h0, cur_mag};
    cnt_inc[cap_pkg::CNT_CCA]  = {17'h0, cur_mag};
    cnt_inc[cap_pkg::CNT_TA]   = {17'h0, temp_res[14:0]};
    cnt_inc[cap_pkg::CNT_AUXA] = {17'h0, st_r.aux_res[14:0]};
    cnt_inc[cap_pkg::CNT_DTC]  = 32'h00000001;
    cnt_inc[cap_pkg::CNT_CTC]  = 32'h00000001;
    cnt_inc[cap_pkg::CNT_TTC]  = 32'h00000001;
    cnt_inc[cap_pkg::CNT_ATC]  = 32'h00000001;
  end

  // Four accumulators, four elapsed-time counters
  for (genvar i = 0; i < cap_pkg::NUM_CNT; i++) begin : g_cnt
    cap_accum #(
      .W (cap_pkg::ACC_W)
    ) u_cnt (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clr      (!pack_above_por),
      .wr_en    (wr_en && cnt_hit(wr_addr) && cnt_idx(wr_addr) == 3'(i)),
      .wr_data  (wr_data),
      .add_en   (cnt_add[i]),
      .add_val  (cnt_inc[i]),
      .value    (cnt_val[i])
    );
  end

  // ********************************************************
  // Register write port, shared by APB and the loader
  // ********************************************************
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 32'h00000000;
    if (st_r.mode == cap_pkg::M_LOAD && nvm_ack) begin
      wr_en   = 1'b1;
      wr_addr = {1'b0, st_r.nvm_idx, 2'h0};
      wr_data = nvm_rdata;
    end else if (psel && penable && pwrite && addr_ok(paddr)) begin
      wr_en   = 1'b1;
      wr_addr = paddr;
      wr_data = pwdata;
    end
  end

  // ********************************************************
  // Read mux
  // ********************************************************
  always_comb begin
    rd_mux = 32'h00000000;
    if (cnt_hit(paddr)) begin
      rd_mux = cnt_val[cnt_idx(paddr)];
    end else begin
      case (paddr)
        cap_pkg::OFS_ACC_CTRL:  rd_mux[7:0] = st_r.acc_ctrl;
        cap_pkg::OFS_CONV_CFG:  rd_mux[7:0] = st_r.conv_cfg;
        cap_pkg::OFS_OP_MODE:   rd_mux[7:0] = st_r.op_mode;
        cap_pkg::OFS_TRIP_CTRL: rd_mux[7:0] = st_r.trip_ctrl;
        cap_pkg::OFS_OFFS_CTRL: rd_mux[7:0] = st_r.offs_ctrl;
        cap_pkg::OFS_OFFS_RES:  rd_mux[15:0] = st_r.offs_res;
        cap_pkg::OFS_CUR_RES:   rd_mux[15:0] = st_r.cur_res;
        cap_pkg::OFS_ITMP_RES:  rd_mux[15:0] = st_r.itmp_res;
        cap_pkg::OFS_ETMP_RES:  rd_mux[15:0] = st_r.etmp_res;
        cap_pkg::OFS_AUX_RES:   rd_mux[15:0] = st_r.aux_res;
        cap_pkg::OFS_STATUS: begin
          rd_mux[2:0] = st_r.mode;
          rd_mux[3]   = st_r.cyc_busy;
        end
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // ********************************************************
  // Trips and wakes
  // ********************************************************
  always_comb begin
    trip_hit = (st_r.trip_ctrl[cap_pkg::PACK_ENT_BIT] && pack_below_trip) ||
               (st_r.trip_ctrl[cap_pkg::AUX_ENT_BIT] && aux_below_trip) ||
               (st_r.trip_ctrl[cap_pkg::CUR_ENT_BIT] && cur_below_trip);
    wake = st_r.mode == cap_pkg::M_SLEEP &&
           ((st_r.trip_ctrl[cap_pkg::CHG_WAKE_BIT] && chg_above_wake) ||
            (st_r.trip_ctrl[cap_pkg::PACK_WAKE_BIT] && pack_above_wake));
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.conv_start = 1'b0;
    run_pick = cap_pkg::M_RUN;

    // Host and loader writes
    if (wr_en) begin
      case (wr_addr)
        cap_pkg::OFS_ACC_CTRL:  st_nxt.acc_ctrl  = wr_data[7:0];
        cap_pkg::OFS_CONV_CFG:  st_nxt.conv_cfg  = wr_data[7:0];
        cap_pkg::OFS_OP_MODE:   st_nxt.op_mode   = wr_data[7:0];
        cap_pkg::OFS_TRIP_CTRL: st_nxt.trip_ctrl = wr_data[7:0];
        cap_pkg::OFS_OFFS_CTRL: st_nxt.offs_ctrl = wr_data[7:0];
        default: ;
      endcase
    end

    // Converter results
    if (conv_valid) begin
      case (conv_chan)
        cap_pkg::CH_CUR:  st_nxt.cur_res  = conv_data;
        cap_pkg::CH_ITMP: st_nxt.itmp_res = conv_data;
        cap_pkg::CH_ETMP: st_nxt.etmp_res = conv_data;
        cap_pkg::CH_AUX:  st_nxt.aux_res  = conv_data;
        cap_pkg::CH_OFFS: begin
          st_nxt.offs_res = conv_data &
            res_mask(st_r.offs_ctrl[cap_pkg::OFFS_RES_LSB +: 3]);
        end
        default: ;
      endcase
    end

    // A wake clears the sleep request
    if (wake) begin
      st_nxt.op_mode[cap_pkg::SLEEP_BIT] = 1'b0;
    end
    // Trip sets the sleep request; set wins over a clear
    if (active && trip_hit) begin
      st_nxt.op_mode[cap_pkg::SLEEP_BIT] = 1'b1;
    end

    if (conv_cycle_done) begin
      st_nxt.cyc_busy = 1'b0;
    end

    // Mode priority
    if (shelf_req) begin
      run_pick = cap_pkg::M_SHELF;
    end else if (st_nxt.op_mode[cap_pkg::SLEEP_BIT]) begin
      run_pick = cap_pkg::M_SLEEP;
    end else if (st_nxt.conv_cfg[cap_pkg::SAMP_BIT]) begin
      run_pick = cap_pkg::M_SAMPLE;
    end else begin
      run_pick = cap_pkg::M_RUN;
    end

    unique case (st_r.mode)
      cap_pkg::M_RESET: begin
        st_nxt.nvm_idx = 5'h00;
        if (pack_above_por) begin
          st_nxt.mode = cap_pkg::M_LOAD;
        end
      end
      cap_pkg::M_LOAD: begin
        if (nvm_ack) begin
          st_nxt.nvm_idx = st_r.nvm_idx + 5'h01;
          if (st_r.nvm_idx == 5'(NVM_WORDS - 1)) begin
            st_nxt.mode = cap_pkg::M_RUN;
          end
        end
      end
      cap_pkg::M_SHELF: begin
        st_nxt.analog_on = 1'b0;
        if (!shelf_req) begin
          st_nxt.mode = cap_pkg::M_RUN;
        end
      end
      cap_pkg::M_RUN: begin
        st_nxt.mode = run_pick;
        st_nxt.analog_on = 1'b1;
        if (!st_r.cyc_busy && !st_r.conv_start) begin
          st_nxt.conv_start = 1'b1;
          st_nxt.cyc_busy = 1'b1;
        end
      end
      cap_pkg::M_SAMPLE: begin
        st_nxt.mode = run_pick;
        st_nxt.analog_on = 1'b1;
        if (tick) begin
          if (st_r.samp_cnt >= lim({1'b0, st_r.conv_cfg[cap_pkg::DIV_LSB +: 3]})) begin
            st_nxt.samp_cnt = '0;
            if (!st_r.cyc_busy) begin
              st_nxt.conv_start = 1'b1;
              st_nxt.cyc_busy = 1'b1;
            end
          end else begin
            st_nxt.samp_cnt = st_r.samp_cnt + SW'(1);
          end
        end
      end
      cap_pkg::M_SLEEP: begin
        st_nxt.mode = run_pick;
        st_nxt.analog_on = st_nxt.cyc_busy;
        if (slp_tick) begin
          if (st_r.slp_cnt >= lim(4'(st_r.conv_cfg[cap_pkg::DIV_LSB +: 3]) +
                                  4'(st_r.op_mode[cap_pkg::DIV_LSB +: 3]))) begin
            st_nxt.slp_cnt = '0;
            if (!st_r.cyc_busy) begin
              st_nxt.conv_start = 1'b1;
              st_nxt.cyc_busy = 1'b1;
              st_nxt.analog_on = 1'b1;
            end
          end else begin
            st_nxt.slp_cnt = st_r.slp_cnt + SW'(1);
          end
        end
      end
      default: begin
        st_nxt.mode = cap_pkg::M_RESET;
      end
    endcase

    // Interval counters restart on any mode change
    if (st_nxt.mode != st_r.mode) begin
      st_nxt.samp_cnt = '0;
      st_nxt.slp_cnt = '0;
    end

    st_nxt.offs_act = st_nxt.analog_on &&
                      st_nxt.offs_ctrl[cap_pkg::OFFS_EN_BIT];

    // APB read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      st_nxt.prdata = rd_mux;
    end

    // Low pack voltage holds everything in reset
    if (!pack_above_por) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign prdata          = st_r.prdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !addr_ok(paddr);
  assign conv_start      = st_r.conv_start;
  assign analog_on       = st_r.analog_on;
  assign offs_cal_active = st_r.offs_act;
  assign nvm_rd          = st_r.mode == cap_pkg::M_LOAD;
  assign nvm_addr        = st_r.nvm_idx;
  assign mode            = st_r.mode;
endmodule : cap_core
`default_nettype wire

// [hw/cap_pkg.sv]
// Constants and types for the charge accumulation and power mode core
//
// Contract
// - Offset calibration enabled: ground converter input, convert, store offset result.
// - Four 32-bit accumulators and four 32-bit elapsed-time counters.
// - Enabled accumulator adds its source result every half second.
// - Fixed sources: current, internal or external temperature, aux analog.
// - Accumulated resolution follows source resolution, fifteen bits at most.
// - Sign zero: magnitude added to charge accumulator.
// - Sign one: magnitude added to discharge accumulator instead.
// - Charge and discharge accumulators change only with accumulate enable set.
// - Charge time counter counts twice a second while charging.
// - Discharge time counter counts twice a second while discharging.
// - Held in reset while pack voltage is below power-on threshold.
// - Above threshold, counters and registers load from nonvolatile memory.
// - Run mode follows completed initialisation.
// - Run repeats conversion cycles, updates every half second.
// - Stay in Run while powered and no other mode active.
// - Sample mode while host holds the sample bit set.
// - Clearing the sample bit returns to Run.
// - Sample interval is two to the sample divider half seconds.
// - Accumulation keeps half-second rate in Sample and Sample-Sleep.
// - Sleep timed by separate timer, analog off, one conversion set per wake.
// - Sample-Sleep entered on any enabled trip or host sleep bit.
// - Sleep interval is 2^sample_div times 2^sleep_div half seconds.
// - Leave sleep on sleep bit clear or enabled charge wake.
// - Leave sleep on enabled pack voltage wake.
// - Results are sign and fifteen magnitude bits, zero padded below.
package cap_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned HALF_SEC_MS  = 500;
  localparam int unsigned HALF_SEC_CYC = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int unsigned ACC_W        = 32;
  localparam int unsigned RES_W        = 16;
  localparam int unsigned MAG_W        = 15;
  localparam int unsigned NUM_CNT      = 8;
  localparam int unsigned NVM_WORDS    = 18;
  localparam int unsigned SLP_CNT_W    = 14;

  // Register byte offsets
  localparam logic [7:0] OFS_ACC_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CONV_CFG  = 8'h04;
  localparam logic [7:0] OFS_OP_MODE   = 8'h08;
  localparam logic [7:0] OFS_TRIP_CTRL = 8'h0C;
  localparam logic [7:0] OFS_OFFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_OFFS_RES  = 8'h14;
  localparam logic [7:0] OFS_CUR_RES   = 8'h18;
  localparam logic [7:0] OFS_ITMP_RES  = 8'h1C;
  localparam logic [7:0] OFS_ETMP_RES  = 8'h20;
  localparam logic [7:0] OFS_AUX_RES   = 8'h24;
  localparam logic [7:0] OFS_CNT_BASE  = 8'h28;
  localparam logic [7:0] OFS_CNT_LAST  = 8'h44;
  localparam logic [7:0] OFS_STATUS    = 8'h48;

  // Counter slots
  localparam int unsigned CNT_DCA  = 0;
  localparam int unsigned CNT_CCA  = 1;
  localparam int unsigned CNT_TA   = 2;
  localparam int unsigned CNT_AUXA = 3;
  localparam int unsigned CNT_DTC  = 4;
  localparam int unsigned CNT_CTC  = 5;
  localparam int unsigned CNT_TTC  = 6;
  localparam int unsigned CNT_ATC  = 7;

  // Converter channels
  localparam logic [2:0] CH_CUR  = 3'h0;
  localparam logic [2:0] CH_ITMP = 3'h1;
  localparam logic [2:0] CH_ETMP = 3'h2;
  localparam logic [2:0] CH_AUX  = 3'h5;
  localparam logic [2:0] CH_OFFS = 3'h6;

  // Field positions
  localparam int unsigned ACC_EN_BIT   = 0;
  localparam int unsigned TEMP_SEL_BIT = 1;
  localparam int unsigned TEMP_EN_BIT  = 2;
  localparam int unsigned AUX_EN_BIT   = 3;
  localparam int unsigned SAMP_BIT     = 0;
  localparam int unsigned DIV_LSB      = 1;
  localparam int unsigned SLEEP_BIT    = 0;
  localparam int unsigned PACK_ENT_BIT = 0;
  localparam int unsigned AUX_ENT_BIT  = 1;
  localparam int unsigned CUR_ENT_BIT  = 2;
  localparam int unsigned CHG_WAKE_BIT = 3;
  localparam int unsigned PACK_WAKE_BIT = 4;
  localparam int unsigned OFFS_EN_BIT  = 7;
  localparam int unsigned OFFS_RES_LSB = 4;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  typedef enum logic [2:0] {
    M_RESET  = 3'h0,
    M_LOAD   = 3'h1,
    M_RUN    = 3'h3,
    M_SAMPLE = 3'h2,
    M_SLEEP  = 3'h6,
    M_SHELF  = 3'h7
  } cap_mode_t;
endpackage : cap_pkg

// [hw/cap_tick_div.sv]
// Divider producing a one-cycle enable pulse every CYC cycles
`timescale 1ns/1ps
`default_nettype none
module cap_tick_div #(
  parameter int unsigned CYC = cap_pkg::HALF_SEC_CYC
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      tick
);
  localparam int unsigned W = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } cap_div_st_t;

  cap_div_st_t st_r;
  cap_div_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : cap_tick_div
`default_nettype wire

// [hw/cap_accum.sv]
// One 32-bit accumulator or elapsed-time counter
`timescale 1ns/1ps
`default_nettype none
module cap_accum #(
  parameter int unsigned W = cap_pkg::ACC_W
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         clr,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         add_en,
  input  wire logic [W-1:0] add_val,
  output logic      [W-1:0] value
);
  typedef struct packed {
    logic [W-1:0] val;
  } cap_acc_st_t;

  cap_acc_st_t st_r;
  cap_acc_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.val = '0;
    end else if (wr_en) begin
      st_nxt.val = wr_data;
    end else if (add_en) begin
      st_nxt.val = st_r.val + add_val;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.val;
endmodule : cap_accum
`default_nettype wire

// [bench/cap_core_sva.sv]
// Port checker for the charge accumulation core
`timescale 1ns/1ps
`default_nettype none
module cap_core_sva #(
  parameter int unsigned NVM_WORDS = cap_pkg::NVM_WORDS
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       pack_above_por,
  input wire logic       shelf_req,
  input wire logic       nvm_ack,
  input wire logic [4:0] nvm_addr,
  input wire logic       conv_start,
  input wire logic       conv_cycle_done,
  input wire logic       analog_on,
  input wire logic       offs_cal_active,
  input wire logic [2:0] mode
);
  // ****************
  // Mode and conversion properties
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_por; !pack_above_por |=> mode == 3'h0; endproperty
  a_por: assert property (p_por) else $error("not cleared below threshold");
  property p_load; mode == 3'h0 && pack_above_por && !shelf_req |=> mode == 3'h1; endproperty
  a_load: assert property (p_load) else $error("no load after power up");
  property p_step;
    mode == 3'h1 && nvm_ack && pack_above_por && !shelf_req && nvm_addr != 5'(NVM_WORDS - 1)
    |=> nvm_addr == $past(nvm_addr) + 5'h01;
  endproperty
  a_step: assert property (p_step) else $error("load word index stuck");
  property p_done;
    mode == 3'h1 && nvm_ack && pack_above_por && !shelf_req && nvm_addr == 5'(NVM_WORDS - 1)
    |=> mode == 3'h3;
  endproperty
  a_done: assert property (p_done) else $error("no run after load");
  property p_cont;
    mode == 3'h3 && conv_cycle_done ##1 mode == 3'h3 && pack_above_por |-> ##[0:1] conv_start;
  endproperty
  a_cont: assert property (p_cont) else $error("run cycle not restarted");
  property p_once; conv_start |=> !conv_start [*2]; endproperty
  a_once: assert property (p_once) else $error("second start before done");
  property p_offs; offs_cal_active |-> analog_on; endproperty
  a_offs: assert property (p_offs) else $error("offset cal with analog off");
  property p_shelf; shelf_req && pack_above_por && mode[1] |=> mode == 3'h7; endproperty
  a_shelf: assert property (p_shelf) else $error("shelf request not first");
endmodule : cap_core_sva
bind cap_core cap_core_sva #(.NVM_WORDS(NVM_WORDS)) cap_core_sva_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .pack_above_por(pack_above_por),
  .shelf_req(shelf_req), .nvm_ack(nvm_ack), .nvm_addr(nvm_addr), .conv_start(conv_start),
  .conv_cycle_done(conv_cycle_done), .analog_on(analog_on),
  .offs_cal_active(offs_cal_active), .mode(mode));
`default_nettype wire

// [bench/cap_conv_model.sv]
// Converter and nonvolatile store model
`timescale 1ns/1ps
`default_nettype none
module cap_conv_model (
  input  wire logic        core_clk,
  input  wire logic        conv_start,
  input  wire logic        offs_cal_active,
  input  wire logic [15:0] cur_val,
  input  wire logic        nvm_rd,
  input  wire logic [4:0]  nvm_addr,
  output logic             conv_valid,
  output logic      [2:0]  conv_chan,
  output logic      [15:0] conv_data,
  output logic             conv_cycle_done,
  output logic             nvm_ack,
  output logic      [31:0] nvm_rdata
);
  // ***********
  // Responses
  // ***********
  assign nvm_rdata = nvm_rd ? {31'h0, nvm_addr == 5'h00} : 32'hA5A5A5A5;
  always @(posedge core_clk) nvm_ack <= nvm_rd && !nvm_ack;
  initial begin
    {conv_valid, conv_chan, conv_cycle_done} = '0;
    conv_data = 16'h5A5A;
    forever begin
      @(posedge core_clk);
      if (conv_start) begin
        repeat (2) @(posedge core_clk);
        conv_valid <= 1'b1;
        conv_chan  <= 3'h0;
        conv_data  <= cur_val;
        @(posedge core_clk);
        conv_valid <= offs_cal_active;
        conv_chan  <= 3'h6;
        conv_data  <= 16'h0123;
        @(posedge core_clk);
        conv_valid      <= 1'b0;
        conv_data       <= ~conv_data;
        conv_cycle_done <= 1'b1;
        @(posedge core_clk);
        conv_cycle_done <= 1'b0;
      end
    end
  end
endmodule : cap_conv_model
`default_nettype wire

// [bench/testbench.sv]
// Register level testbench for the charge accumulation core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int P = 32;
  logic        core_clk, sys_rst, psel, penable, pwrite, pack_above_por, shelf_req;
  logic        pready, pslverr, rerr, conv_valid, conv_cycle_done, conv_start;
  logic        analog_on, offs_cal_active, nvm_rd, nvm_ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, nvm_rdata, rdat;
  logic [2:0]  conv_chan, mode, trip;
  logic [1:0]  wake;
  logic [15:0] conv_data, cur_val;
  logic [4:0]  nvm_addr;
  int          mismatches = 0, compares = 0, starts = 0, s0, i;
  // ****************
  // Harness
  // ****************
  cap_core #(.HALF_SEC_CYC(P), .SLP_TICK_CYC(16), .NVM_WORDS(2)) cap_core_inst (
    .pack_below_trip(trip[0]), .aux_below_trip(trip[1]), .cur_below_trip(trip[2]),
    .chg_above_wake(wake[0]), .pack_above_wake(wake[1]), .*);
  cap_conv_model cap_conv_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (conv_start === 1'b1) starts <= starts + 1;
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic ck(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t unexpected value", $time);
    end
  endtask : ck
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
  task automatic rv(input logic [7:0] a, input int m);
    xfer(1'b0, a, 32'h0);
    if (m == 0) ck(rdat === 32'h0);
    else ck(rdat % m === 0 && rdat >= 7 * m && rdat <= 10 * m);
  endtask : rv
  task automatic wm(input logic [2:0] m);
    repeat (60) if (mode !== m) @(posedge core_clk);
    ck(mode === m);
  endtask : wm
  initial begin
    #1_000_000;
    mismatches++;
    close_out();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, shelf_req, trip, wake} = '0;
    {sys_rst, pack_above_por, cur_val} = {2'b11, 16'h0005};
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    wm(cap_pkg::M_RUN);
    xfer(1'b0, 8'h00, 32'h0);
    ck(rdat === 32'h1);
    for (i = 0; i < 2; i++) begin
      cur_val <= i ? 16'h8003 : 16'h0005;
      repeat (20) @(posedge core_clk);
      foreach (wake[k]) xfer(1'b1, 8'h28 + 8'(k * 4), 32'h0);
      foreach (wake[k]) xfer(1'b1, 8'h38 + 8'(k * 4), 32'h0);
      repeat (8 * P) @(posedge core_clk);
      rv(8'h28, i * 3);
      rv(8'h2C, 5 - i * 5);
      rv(8'h38, i);
      rv(8'h3C, 1 - i);
    end
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h28, 32'h0);
    repeat (4 * P) @(posedge core_clk);
    rv(8'h28, 0);
    xfer(1'b1, 8'h10, 32'hF0);
    repeat (40) @(posedge core_clk);
    xfer(1'b0, 8'h14, 32'h0);
    ck(rdat === 32'h0123);
    xfer(1'b0, 8'h4C, 32'h0);
    ck(rerr === 1'b1);
    xfer(1'b1, 8'h04, 32'h3);
    wm(cap_pkg::M_SAMPLE);
    s0 = starts;
    repeat (16 * P) @(posedge core_clk);
    ck((starts - s0) inside {[7:9]});
    xfer(1'b1, 8'h04, 32'h0);
    wm(cap_pkg::M_RUN);
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, 8'h0C, 32'(1 << i));
      trip[i] <= 1'b1;
      wm(cap_pkg::M_SLEEP);
      trip[i] <= 1'b0;
      xfer(1'b1, 8'h08, 32'h0);
      wm(cap_pkg::M_RUN);
    end
    for (i = 0; i < 2; i++) begin
      xfer(1'b1, 8'h0C, 32'(8 << i));
      xfer(1'b1, 8'h08, 32'h3);
      wm(cap_pkg::M_SLEEP);
      s0 = starts;
      repeat (128) @(posedge core_clk);
      ck((starts - s0) inside {[3:5]});
      wake[i] <= 1'b1;
      wm(cap_pkg::M_RUN);
      wake[i] <= 1'b0;
    end
    xfer(1'b1, 8'h08, 32'h1);
    shelf_req <= 1'b1;
    wm(cap_pkg::M_SHELF);
    shelf_req <= 1'b0;
    pack_above_por <= 1'b0;
    repeat (5) @(posedge core_clk);
    ck(mode === cap_pkg::M_RESET);
    pack_above_por <= 1'b1;
    wm(cap_pkg::M_RUN);
    xfer(1'b0, 8'h00, 32'h0);
    ck(rdat === 32'h1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
